// *** pfst_pkg.sv ***
// constants, field layouts and carriers for the fault status bank
package pfst_pkg;

  // number of regulated outputs, one page each
  localparam int PFST_PAGES = 2;

  // command codes that the bank answers
  localparam logic [7:0] PFST_CMD_VOUT = 8'h7a;
  localparam logic [7:0] PFST_CMD_IOUT = 8'h7b;
  localparam logic [7:0] PFST_CMD_INPUT = 8'h7c;
  localparam logic [7:0] PFST_CMD_TEMP = 8'h7d;
  localparam logic [7:0] PFST_CMD_CML = 8'h7e;
  localparam logic [7:0] PFST_CMD_VENDOR = 8'h80;
  localparam logic [7:0] PFST_CMD_VIN = 8'h88;
  localparam logic [7:0] PFST_CMD_IIN = 8'h89;

  // output voltage byte
  localparam int PFST_VOUT_OV = 7;
  localparam int PFST_VOUT_UV = 4;
  localparam int PFST_VOUT_MAX = 3;
  // output current byte
  localparam int PFST_IOUT_OC = 7;
  localparam int PFST_IOUT_OC_UV = 6;
  localparam int PFST_IOUT_SHARE = 3;
  // input byte
  localparam int PFST_IN_OV = 7;
  localparam int PFST_IN_UV = 3;
  localparam int PFST_IN_OC = 2;
  // temperature byte
  localparam int PFST_TEMP_OT = 7;
  localparam int PFST_TEMP_OT_WARN = 6;
  localparam int PFST_TEMP_UT = 4;
  // communication, logic and memory byte
  localparam int PFST_CML_CMD = 7;
  localparam int PFST_CML_DATA = 6;
  localparam int PFST_CML_PEC = 5;
  localparam int PFST_CML_MEM = 4;
  localparam int PFST_CML_CPU = 3;
  localparam int PFST_CML_COMM = 1;
  localparam int PFST_CML_OTHER = 0;
  // vendor byte
  localparam int PFST_VEND_OTP_FULL = 1;
  // summary word
  localparam int PFST_SUM_VOUT = 15;
  localparam int PFST_SUM_IOUT = 14;
  localparam int PFST_SUM_INPUT = 13;
  localparam int PFST_SUM_VENDOR = 12;

  // values after reset
  localparam logic [7:0] PFST_FLAGS_RST = 8'h00;
  localparam logic [15:0] PFST_WORD_RST = 16'h0000;
  // answer lengths in bytes
  localparam logic [1:0] PFST_LEN_NONE = 2'h0;
  localparam logic [1:0] PFST_LEN_BYTE = 2'h1;
  localparam logic [1:0] PFST_LEN_WORD = 2'h2;

  // per-output fault events, one-cycle pulses on mclk
  typedef struct packed {
    logic ov;
    logic uv;
    logic vmax_warn;
    logic oc;
    logic oc_uv;
    logic share;
  } pfst_out_evt_s;

  // unit-wide fault events, one-cycle pulses on mclk
  typedef struct packed {
    logic vin_ov;
    logic vin_uv;
    logic iin_oc;
    logic ot_fault;
    logic ot_warn;
    logic ut_fault;
    logic cml_cmd;
    logic cml_data;
    logic cml_pec;
    logic cml_mem;
    logic cml_cpu;
    logic cml_comm;
    logic cml_other;
    logic otp_full;
  } pfst_glb_evt_s;

  // request from the serial side
  typedef struct packed {
    logic clear;
    logic page;
    logic [7:0] code;
  } pfst_req_s;

  // answer to the serial side
  typedef struct packed {
    logic invalid;
    logic [1:0] len;
    logic [15:0] data;
  } pfst_ans_s;

endpackage

// *** pfst_bank.sv ***
// fault status and input telemetry bank with serial-side crossing
`timescale 1ns/1ps

module pfst_bank
  import pfst_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire pfst_out_evt_s [PFST_PAGES-1:0] out_evt,
  input wire pfst_glb_evt_s glb_evt,
  input wire logic vin_above_uv,
  input wire logic [15:0] vin_mv,
  input wire logic [15:0] iin_centiamp,
  output logic [15:0] summary_word,
  input wire logic link_clk,
  input wire logic req_valid,
  output logic req_ready,
  input wire pfst_req_s req,
  output logic rd_valid,
  output pfst_ans_s rd_ans
);

  ////////////////////////////////////////////////////////////////////////////
  // byte builders: only defined positions can ever be set
  // positions come from the package so a moved bit is one edit

  function automatic logic [7:0] vout_bits(input pfst_out_evt_s e);
    logic [7:0] b;
    b = PFST_FLAGS_RST;
    b[PFST_VOUT_OV] = e.ov;
    b[PFST_VOUT_UV] = e.uv;
    b[PFST_VOUT_MAX] = e.vmax_warn;
    return b;
  endfunction

  function automatic logic [7:0] iout_bits(input pfst_out_evt_s e);
    logic [7:0] b;
    b = PFST_FLAGS_RST;
    b[PFST_IOUT_OC] = e.oc;
    b[PFST_IOUT_OC_UV] = e.oc_uv;
    b[PFST_IOUT_SHARE] = e.share;
    return b;
  endfunction

  // sticky update where a new event beats a clear in the same cycle
  // clr only ever comes from a host clear request
  function automatic logic [7:0] sticky(input logic [7:0] cur,
                                        input logic [7:0] set,
                                        input logic clr);
    return set | (cur & {8{~clr}});
  endfunction

  // codes the bank answers; any other code in a read is refused and flagged
  function automatic logic code_known(input logic [7:0] c);
    logic k;
    k = 1'b0;
    case (c)
      PFST_CMD_VOUT,
      PFST_CMD_IOUT,
      PFST_CMD_INPUT,
      PFST_CMD_TEMP,
      PFST_CMD_CML,
      PFST_CMD_VENDOR,
      PFST_CMD_VIN,
      PFST_CMD_IIN: k = 1'b1;
      default: k = 1'b0;
    endcase
    return k;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link side: request capture and answer return

  logic req_tgl_q;
  logic busy_q;
  pfst_req_s req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_seen_q;
  logic rd_valid_q;
  pfst_ans_s rd_ans_q;
  logic ack_tgl_q;
  pfst_ans_s ans_q;
  wire logic req_take;
  wire logic ack_new;

  // one request in flight; the held request must stay still while crossing
  // ready is combinational so a request offered with the answer is taken
  // on the very next edge; no extra turnaround cycle
  assign req_ready = ~busy_q;
  assign req_take = req_valid & ~busy_q;
  assign ack_new = ack_s2_q ^ ack_seen_q;

  // request register and toggle
  // the toggle, not a level, crosses: one change of it is one request
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= '0;
      req_tgl_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      if (req_take) begin
        req_q <= req;
        req_tgl_q <= ~req_tgl_q;
      end
      busy_q <= req_take | (busy_q & ~ack_new);
    end
  end

  // acknowledge toggle synchroniser
  // only the second stage and its delayed copy ack_seen_q are read by anything else
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_seen_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_seen_q <= ack_s2_q;
    end
  end

  // answer capture; ans_q is stable once the toggle has arrived
  // ans_q changed on the same mclk edge as its toggle, two link edges
  // before ack_new can be seen here, so it has settled
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_q <= 1'b0;
      rd_ans_q <= '0;
    end else begin
      rd_valid_q <= ack_new;
      if (ack_new) begin
        rd_ans_q <= ans_q;
      end
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_ans = rd_ans_q;

  ////////////////////////////////////////////////////////////////////////////
  // mclk side: request detection

  logic req_s1_q;
  logic req_s2_q;
  logic req_seen_q;
  wire logic req_new;
  wire logic do_clear;
  wire logic do_read;

  // request toggle synchroniser
  // req_q itself is not synchronised: it is held still while busy
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_seen_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_seen_q <= req_s2_q;
    end
  end

  // a clear wipes both pages and every global byte at once; the host
  // cannot clear a single flag
  assign req_new = req_s2_q ^ req_seen_q;
  assign do_clear = req_new & req_q.clear;
  assign do_read = req_new & ~req_q.clear;

  ////////////////////////////////////////////////////////////////////////////
  // paged flags, one pair of bytes per output

  logic [7:0] vout_q [PFST_PAGES];
  logic [7:0] iout_q [PFST_PAGES];
  wire logic [PFST_PAGES-1:0] any_vout;
  wire logic [PFST_PAGES-1:0] any_iout;

  // events reach every page in parallel; a page only steers reads
  generate
    for (genvar p = 0; p < PFST_PAGES; p++) begin : g_page
      // per-output sticky bytes
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          vout_q[p] <= PFST_FLAGS_RST;
          iout_q[p] <= PFST_FLAGS_RST;
        end else begin
          vout_q[p] <= sticky(vout_q[p], vout_bits(out_evt[p]), do_clear);
          iout_q[p] <= sticky(iout_q[p], iout_bits(out_evt[p]), do_clear);
        end
      end
      assign any_vout[p] = |vout_q[p];
      assign any_iout[p] = |iout_q[p];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // global flags

  // global bytes ignore the page entirely
  logic [7:0] input_q;
  logic [7:0] temp_q;
  logic [7:0] cml_q;
  logic [7:0] vend_q;
  logic uv_armed_q;
  wire logic [7:0] input_set;
  wire logic [7:0] temp_set;
  wire logic [7:0] cml_set;
  wire logic [7:0] vend_set;
  wire logic bad_code;

  // input undervoltage only counts once vin has been seen above threshold
  assign input_set = {
    glb_evt.vin_ov,
    3'h0,
    glb_evt.vin_uv & uv_armed_q,
    glb_evt.iin_oc,
    2'h0
  };
  // temperature and cml bytes do not reach the summary word
  assign temp_set = {
    glb_evt.ot_fault,
    glb_evt.ot_warn,
    1'b0,
    glb_evt.ut_fault,
    4'h0
  };
  // an unknown code read by the host flags itself as a bad command
  assign cml_set = {
    glb_evt.cml_cmd | bad_code,
    glb_evt.cml_data,
    glb_evt.cml_pec,
    glb_evt.cml_mem,
    glb_evt.cml_cpu,
    1'b0,
    glb_evt.cml_comm,
    glb_evt.cml_other
  };
  assign vend_set = {6'h00, glb_evt.otp_full, 1'b0};

  // arming is one-way; a clear does not mask the flag again
  // limitation: a brown-out after arming is reported, never re-masked
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      uv_armed_q <= 1'b0;
    end else begin
      uv_armed_q <= uv_armed_q | vin_above_uv;
    end
  end

  // global sticky bytes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      input_q <= PFST_FLAGS_RST;
      temp_q <= PFST_FLAGS_RST;
      cml_q <= PFST_FLAGS_RST;
      vend_q <= PFST_FLAGS_RST;
    end else begin
      input_q <= sticky(input_q, input_set, do_clear);
      temp_q <= sticky(temp_q, temp_set, do_clear);
      cml_q <= sticky(cml_q, cml_set, do_clear);
      vend_q <= sticky(vend_q, vend_set, do_clear);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // telemetry, passed through as raw signed counts

  logic [15:0] vin_q;
  logic [15:0] iin_q;

  // sampled every cycle; scaling is left to the host
  // one cycle old at most; the signed counts are not range checked
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vin_q <= PFST_WORD_RST;
      iin_q <= PFST_WORD_RST;
    end else begin
      vin_q <= vin_mv;
      iin_q <= iin_centiamp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // summary word

  logic [15:0] summary_q;
  wire logic [15:0] summary_d;

  // registered so the word never glitches while flags settle
  // bit 12 mirrors the vendor byte; bits 11:0 are never driven high
  assign summary_d = {|any_vout, |any_iout, |input_q, |vend_q,
                      12'h000};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      summary_q <= PFST_WORD_RST;
    end else begin
      summary_q <= summary_d;
    end
  end

  assign summary_word = summary_q;

  ////////////////////////////////////////////////////////////////////////////
  // read lookup

  wire logic [7:0] sel_vout;
  wire logic [7:0] sel_iout;
  pfst_ans_s ans_d;

  // page only steers the two paged bytes
  // req_q is held still by the link side while busy, so these selects
  // are stable for the whole lookup
  assign sel_vout = vout_q[req_q.page];
  assign sel_iout = iout_q[req_q.page];
  assign bad_code = do_read & ~code_known(req_q.code);

  // code to answer
  always_comb begin
    ans_d.invalid = ~code_known(req_q.code);
    ans_d.len = PFST_LEN_BYTE;
    ans_d.data = PFST_WORD_RST;
    case (req_q.code)
      PFST_CMD_VOUT: ans_d.data = {8'h00, sel_vout};
      PFST_CMD_IOUT: ans_d.data = {8'h00, sel_iout};
      PFST_CMD_INPUT: ans_d.data = {8'h00, input_q};
      PFST_CMD_TEMP: ans_d.data = {8'h00, temp_q};
      PFST_CMD_CML: ans_d.data = {8'h00, cml_q};
      PFST_CMD_VENDOR: ans_d.data = {8'h00, vend_q};
      PFST_CMD_VIN: begin
        ans_d.len = PFST_LEN_WORD;
        ans_d.data = vin_q;
      end
      PFST_CMD_IIN: begin
        ans_d.len = PFST_LEN_WORD;
        ans_d.data = iin_q;
      end
      default: begin
        ans_d.data = PFST_WORD_RST;
        ans_d.len = PFST_LEN_NONE;
      end
    endcase
  end

  // answer hold and acknowledge toggle; a clear answers with no data
  // so a host cannot mistake the clear answer for a reading
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ans_q <= '0;
      ack_tgl_q <= 1'b0;
    end else if (req_new) begin
      ans_q <= req_q.clear ? '0 : ans_d;
      ack_tgl_q <= ~ack_tgl_q;
    end
  end

endmodule

// *** pfst_bank_chk.sv ***
// port assertions for the fault status bank
`timescale 1ns/1ps
module pfst_bank_chk
  import pfst_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire pfst_out_evt_s [PFST_PAGES-1:0] out_evt,
  input wire pfst_glb_evt_s glb_evt,
  input wire logic [15:0] summary_word,
  input wire logic link_clk,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rd_valid,
  input wire pfst_ans_s rd_ans
);
  // a request handed over on the link side
  sequence s_take;
    req_valid && req_ready;
  endsequence
  // the answer pulse with its ready
  sequence s_answer;
    rd_valid && req_ready ##1 !rd_valid;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_busy_after_take: assert property (@(posedge link_clk) disable iff (!rst_n)
    s_take |=> !req_ready) else $error("ready stayed high after take");
  a_answer_bound: assert property (@(posedge link_clk) disable iff (!rst_n)
    s_take |-> ##[2:8] s_answer) else $error("answer late or malformed");
  a_byte_hi_zero: assert property (@(posedge link_clk) disable iff (!rst_n)
    rd_valid && rd_ans.len == PFST_LEN_BYTE |-> rd_ans.data[15:8] == 8'h00)
    else $error("byte answer has upper bits set");
  a_invalid_empty: assert property (@(posedge link_clk) disable iff (!rst_n)
    rd_valid && rd_ans.invalid |-> rd_ans.len == PFST_LEN_NONE &&
    rd_ans.data == 16'h0000) else $error("refused answer carries data");
  ////////////////////////////////////////////////////////////////////////
  a_sum_vout: assert property (@(posedge mclk) disable iff (!rst_n)
    out_evt[0].ov || out_evt[1].uv |-> ##2 summary_word[15])
    else $error("summary vout bit missing");
  a_sum_iout: assert property (@(posedge mclk) disable iff (!rst_n)
    out_evt[0].oc || out_evt[1].share |-> ##2 summary_word[14])
    else $error("summary iout bit missing");
  a_sum_input: assert property (@(posedge mclk) disable iff (!rst_n)
    glb_evt.vin_ov || glb_evt.iin_oc |-> ##2 summary_word[13])
    else $error("summary input bit missing");
  a_sum_unused: assert property (@(posedge mclk) disable iff (!rst_n)
    summary_word[11:0] == 12'h000) else $error("summary unused bits set");
  a_sum_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    out_evt[1].ov |-> ##2 summary_word[15] [*4])
    else $error("summary vout bit not held");
endmodule

bind pfst_bank pfst_bank_chk i_chk(.mclk, .rst_n, .out_evt, .glb_evt,
  .summary_word, .link_clk, .req_valid, .req_ready, .rd_valid, .rd_ans);

// *** pfst_host.sv ***
// link-side host model issuing one request at a time
`timescale 1ns/1ps
module pfst_host
  import pfst_pkg::*;
(
  input wire logic link_clk,
  input wire logic req_ready,
  input wire logic rd_valid,
  output logic req_valid,
  output pfst_req_s req
);
  // idle bus at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // hold the request until ready is seen, then wait for the answer
  task automatic xfer(input pfst_req_s r, input int stall, output bit ok);
    int n;
    repeat (stall + 1) @(negedge link_clk);
    req_valid = 1'b1;
    req = r;
    for (n = 0; n < 40 && !req_ready; n++) @(negedge link_clk);
    ok = req_ready;
    @(posedge link_clk);
    @(negedge link_clk);
    req_valid = 1'b0;
    // released lines must not keep the last value
    req = pfst_req_s'(~r);
    for (n = 0; n < 40 && !rd_valid; n++) @(negedge link_clk);
    ok = ok && rd_valid;
  endtask
endmodule

// *** pfst_bank_test.sv ***
// self-checking bench for the fault status bank
`timescale 1ns/1ps
module pfst_bank_test import pfst_pkg::*;;
  logic mclk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, vin_above_uv = 1'b0;
  logic req_valid, req_ready, rd_valid;
  logic [15:0] vin_mv = 16'h0000, iin_centiamp = 16'h0000, summary_word;
  pfst_out_evt_s [PFST_PAGES-1:0] out_evt = '0;
  pfst_glb_evt_s glb_evt = '0, g;
  pfst_req_s req;
  pfst_ans_s rd_ans;
  pfst_ans_s exp_q[$];
  logic [7:0] vq[2], iq[2], inq, tq, cq, mq;
  logic [7:0] codes[8] = '{8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80,
    8'h88, 8'h89};
  int seed = 32'h75cc, err_total = 0, n_compared = 0;
  bit armed = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // link clock phase is offset so edges never meet the core clock
  always #25 mclk = ~mclk;
  always begin
    if ($time == 0) #13;
    #62.5 link_clk = ~link_clk;
  end
  pfst_bank i_dut(.mclk, .rst_n, .out_evt, .glb_evt, .vin_above_uv, .vin_mv,
    .iin_centiamp, .summary_word, .link_clk, .req_valid, .req_ready, .req,
    .rd_valid, .rd_ans);
  pfst_host i_host(.link_clk, .req_ready, .rd_valid, .req_valid, .req);
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(string what, logic [18:0] e, logic [18:0] s);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic results;
    cmp("pending answers", 19'h0, 19'(exp_q.size()));
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // answers are sampled mid-cycle, away from the launching edge
  always @(negedge link_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) cmp("spurious answer", 19'h7ffff, rd_ans);
      else cmp("answer", exp_q.pop_front(), rd_ans);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic pfst_ans_s ans_of(logic [7:0] c, logic p);
    logic [7:0] b;
    case (c)
      8'h7a: b = vq[p];
      8'h7b: b = iq[p];
      8'h7c: b = inq;
      8'h7d: b = tq;
      8'h7e: b = cq;
      8'h80: b = mq;
      8'h88: return '{1'b0, PFST_LEN_WORD, vin_mv};
      8'h89: return '{1'b0, PFST_LEN_WORD, iin_centiamp};
      default: return '{1'b1, PFST_LEN_NONE, 16'h0000};
    endcase
    return '{1'b0, PFST_LEN_BYTE, {8'h00, b}};
  endfunction
  task automatic rd(logic [7:0] c, logic p, logic clr);
    pfst_ans_s e;
    bit ok;
    e = clr ? pfst_ans_s'(0) : ans_of(c, p);
    exp_q.push_back(e);
    i_host.xfer('{clr, p, c}, $unsigned($random(seed)) % 3, ok);
    if (!ok) begin
      err_total++;
      results();
    end
    if (clr) {vq[0], vq[1], iq[0], iq[1], inq, tq, cq, mq} = '0;
    else if (e.invalid) cq[7] = 1'b1;
  endtask
  // every code on both pages
  task automatic rd_all;
    for (int p = 0; p < 2; p++)
      foreach (codes[i]) rd(codes[i], p[0], 1'b0);
  endtask
  // one-cycle event pulse, model update, summary check
  task automatic hit(pfst_out_evt_s a, pfst_out_evt_s b, pfst_glb_evt_s q);
    @(negedge mclk);
    out_evt = {b, a};
    glb_evt = q;
    @(negedge mclk);
    out_evt = '0;
    glb_evt = '0;
    for (int p = 0; p < 2; p++) begin
      vq[p] |= {out_evt_v(p, a, b, 0), 2'b00, out_evt_v(p, a, b, 1),
        out_evt_v(p, a, b, 2), 3'b000};
      iq[p] |= {out_evt_v(p, a, b, 3), out_evt_v(p, a, b, 4), 2'b00,
        out_evt_v(p, a, b, 5), 3'b000};
    end
    inq |= {q.vin_ov, 3'b000, q.vin_uv & armed, q.iin_oc, 2'b00};
    tq |= {q.ot_fault, q.ot_warn, 1'b0, q.ut_fault, 4'h0};
    cq |= {q.cml_cmd, q.cml_data, q.cml_pec, q.cml_mem, q.cml_cpu, 1'b0,
      q.cml_comm, q.cml_other};
    mq |= {6'h00, q.otp_full, 1'b0};
    repeat (3) @(negedge mclk);
    cmp("summary", {3'h0, |(vq[0] | vq[1]), |(iq[0] | iq[1]), |inq, |mq,
      12'h000}, {3'h0, summary_word});
  endtask
  function automatic logic out_evt_v(int p, pfst_out_evt_s a,
    pfst_out_evt_s b, int k);
    logic [5:0] v;
    v = p ? b : a;
    return v[5 - k];
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {vq[0], vq[1], iq[0], iq[1], inq, tq, cq, mq} = '0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    cmp("summary after reset", 19'h0, {3'h0, summary_word});
    cmp("ready after reset", 19'h1, {18'h0, req_ready});
    cmp("answer after reset", 19'h0, rd_ans);
    vin_mv = 16'($random(seed));
    iin_centiamp = 16'($random(seed));
    repeat (3) @(negedge link_clk);
    rd_all();
    $display("reset values and telemetry done");
    g = '0;
    g.vin_uv = 1'b1;
    hit('0, '0, g);
    rd(8'h7c, 1'b0, 1'b0);
    vin_above_uv = 1'b1;
    repeat (3) @(negedge mclk);
    armed = 1'b1;
    hit('0, '0, g);
    rd(8'h7c, 1'b1, 1'b0);
    $display("undervoltage arming done");
    hit('1, '1, '1);
    rd_all();
    rd(8'h00, 1'b0, 1'b1);
    rd_all();
    $display("all flags and clear done");
    rd(8'h7f, 1'b1, 1'b0);
    rd(8'h7e, 1'b0, 1'b0);
    repeat (6) begin
      hit(6'($random(seed)), 6'($random(seed)), 14'($random(seed)));
      vin_mv = 16'($random(seed));
      iin_centiamp = 16'($random(seed));
      @(negedge mclk);
      rd_all();
    end
    $display("random sticky events done");
    @(negedge link_clk);
    results();
  end
endmodule
